// ---- src/tts_pkg.sv ----
package tts_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_TEMP = 8'h00;
  localparam logic [7:0] ADDR_CFG  = 8'h04;
  localparam logic [7:0] ADDR_HYST = 8'h08;
  localparam logic [7:0] ADDR_TOS  = 8'h0C;
  localparam logic [7:0] ADDR_CMD  = 8'h10;
  // field positions
  localparam int CMD_COPY_BIT = 0;
  localparam int CFG_NVB_BIT  = 7;
  // reset values, masks and bus response codes
  localparam logic [6:0]  CFG_RST  = 7'h00;
  localparam logic [15:0] TOS_RST  = 16'h5000;
  localparam logic [15:0] HYST_RST = 16'h4B00;
  localparam logic [15:0] RES9_MASK = 16'hFF80;
  localparam logic [7:0]  LSB_MASK  = 8'hF0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_MHZ     = 250;
  localparam int CONV_9B_MS  = 25;
  localparam int CONV_9B_CYC = CONV_9B_MS * CLK_MHZ * 1000;

  typedef struct packed {
    logic [1:0] res;
    logic [1:0] ft;
    logic       alarm_active_level;
    logic       mode;
    logic       sd;
  } tts_cfg_t;

  typedef enum logic [2:0] {
    ST_START = 3'h1,
    ST_CONV  = 3'h2,
    ST_SHUT  = 3'h4
  } tts_state_t;

  function automatic logic [15:0] tts_res_mask(input logic [1:0] res);
    return 16'($signed(RES9_MASK) >>> res);
  endfunction

  function automatic logic [2:0] tts_need(input logic [1:0] ft);
    case (ft)
      2'h0:    return 3'h1;
      2'h1:    return 3'h2;
      2'h2:    return 3'h4;
      default: return 3'h6;
    endcase
  endfunction
endpackage

// ---- src/tts_conv_timer.sv ----
`timescale 1ns/10ps
module tts_conv_timer import tts_pkg::*; #(
  parameter int BASE_CYC = CONV_9B_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [1:0] res,
  output logic            done
);
  localparam int CW = $clog2(BASE_CYC * 8 + 1);
  if (BASE_CYC < 1) begin : g_chk
    $error("conversion base count must be at least one");
  end

  typedef struct packed {
    logic          busy;
    logic          done;
    logic [1:0]    res;
    logic [CW-1:0] cnt;
  } tts_tmr_t;
  tts_tmr_t q_r, q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    if (start) begin
      q_nxt.busy = 1'b1;
      q_nxt.res  = res;
      q_nxt.cnt  = CW'((CW'(BASE_CYC) << res) - CW'(1));
    end else if (q_r.busy) begin
      if (q_r.cnt == '0) begin
        q_nxt.busy = 1'b0;
        q_nxt.done = 1'b1;
      end else begin
        q_nxt.cnt = q_r.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end
  assign done = q_r.done;

  // busy-cycle tally, read only by the check below
  logic [CW-1:0] len_r;
  always_ff @(posedge clk) begin
    if (!rstn || (ce && start)) begin
      len_r <= '0;
    end else if (ce && q_r.busy) begin
      len_r <= len_r + CW'(1);
    end
  end

  a_conv_len: assert property (@(posedge clk) disable iff (!rstn)
    q_r.done |-> len_r == CW'(CW'(BASE_CYC) << q_r.res))
    else $error("conversion length does not match resolution");
endmodule

// ---- src/tts_limit_cmp.sv ----
`timescale 1ns/10ps
module tts_limit_cmp import tts_pkg::*; (
  input  wire logic [15:0] result,
  input  wire logic [15:0] tos,
  input  wire logic [15:0] hyst,
  input  wire logic [1:0]  res,
  output logic             above,
  output logic             below
);
  logic [15:0] m;
  // limits cut to the active resolution before comparing
  assign m     = tts_res_mask(res);
  assign above = $signed(result & m) > $signed(tos & m);
  assign below = $signed(result & m) < $signed(hyst & m);
endmodule

// ---- src/tts_top.sv ----
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
// Operation
// - resolutions 9..12 bits, 0.5 to 0.0625 step
// - reset resolution is 9 bits
// - conversion time doubles per extra bit
// - each result stored as 16-bit two's complement
// - top result bit is the sign
// - result readable anytime, conversion undisturbed
// - result bits 3..0 always zero
// - data left-justified, unused low bits zero
// - result and limits share one format
// - shutdown finishes conversion, stores, then stands by
// - shutdown entry clears interrupt alarm only
// - bus works in shutdown; clearing resumes
// - start in shutdown: one measurement first
// - limits held in shadow, copy command commits
// - defaults: comparator, active low, 80, 75, one
// - consecutive out-of-limit count 1,2,4,6
// - compare with resolution-truncated limits
// - polarity bit sets alarm level, low default
// - comparator: set over limit, release below hyst
// - interrupt: set over limit, clear by read/shutdown
// - interrupt events alternate over and under
// - limits usable as plain storage
// - resolution codes map to 25..200 ms
// - fault codes map to 1,2,4,6
// - mode bit zero comparator, one interrupt
module tts_top import tts_pkg::*; #(
  parameter int       AW       = 8,
  parameter int       BASE_CYC = CONV_9B_CYC,
  parameter tts_cfg_t PWRUP_CFG = tts_cfg_t'(CFG_RST)
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          ce,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  input  wire logic [11:0]   conv_data,
  output logic               conv_start,
  input  wire logic          nv_busy,
  output logic               nv_copy,
  output logic               standby,
  output logic               alarm_o,
  output logic               alarm_oe
);
  if (AW < 5) begin : g_chk
    $error("address width too small for the register map");
  end

  typedef struct packed {
    tts_state_t      st;
    tts_cfg_t        cfg;
    logic [15:0]     tos;
    logic [15:0]     hyst;
    logic [15:0]     temp;
    logic            alarm;
    logic            low_phase;
    logic [2:0]      fcnt;
    logic            aw_got;
    logic            w_got;
    logic [AW-1:0]   waddr;
    logic [31:0]     wdat;
    logic [3:0]      wstb;
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic            start;
    logic            copy;
    logic            os_oe;
  } tts_main_t;
  tts_main_t q_r, q_nxt;

  logic        tmr_done;
  logic        above;
  logic        below;
  logic        conv_end;
  logic        rd_go;
  logic        wr_go;
  logic        hit;
  logic [15:0] fmt;

  // sample is left-justified, low nibble and unused bits zero
  assign fmt = {conv_data, 4'h0} & tts_res_mask(q_r.cfg.res);

  tts_conv_timer #(
    .BASE_CYC (BASE_CYC)
  ) u_timer (
    .clk   (clk),
    .rstn  (rstn),
    .ce    (ce),
    .start (q_r.start),
    .res   (q_r.cfg.res),
    .done  (tmr_done)
  );

  tts_limit_cmp u_cmp (
    .result (fmt),
    .tos    (q_r.tos),
    .hyst   (q_r.hyst),
    .res    (q_r.cfg.res),
    .above  (above),
    .below  (below)
  );

  assign conv_end = tmr_done && (q_r.st == ST_CONV);
  assign rd_go    = arvalid && q_r.arready;
  assign wr_go    = q_r.aw_got && q_r.w_got && !q_r.bvalid;
  // which event the counter is hunting for
  always_comb begin
    if (q_r.cfg.mode) begin
      hit = q_r.low_phase ? below : above;
    end else begin
      hit = above;
    end
  end

  always_comb begin
    q_nxt = q_r;
    q_nxt.start = 1'b0;
    q_nxt.copy  = 1'b0;
    // write channels are taken in either order
    if (awvalid && q_r.awready) begin
      q_nxt.aw_got = 1'b1;
      q_nxt.waddr  = awaddr;
    end
    if (wvalid && q_r.wready) begin
      q_nxt.w_got = 1'b1;
      q_nxt.wdat  = wdata;
      q_nxt.wstb  = wstrb;
    end
    if (q_r.bvalid && bready) begin
      q_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      q_nxt.aw_got = 1'b0;
      q_nxt.w_got  = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp  = RESP_OKAY;
      case (8'(q_r.waddr))
        ADDR_TEMP: ;
        ADDR_CFG: begin
          if (q_r.wstb[0]) begin
            q_nxt.cfg = tts_cfg_t'(q_r.wdat[6:0]);
          end
        end
        ADDR_HYST: begin
          // trip points are plain storage as well
          if (q_r.wstb[0]) begin
            q_nxt.hyst[7:0] = q_r.wdat[7:0] & LSB_MASK;
          end
          if (q_r.wstb[1]) begin
            q_nxt.hyst[15:8] = q_r.wdat[15:8];
          end
        end
        ADDR_TOS: begin
          if (q_r.wstb[0]) begin
            q_nxt.tos[7:0] = q_r.wdat[7:0] & LSB_MASK;
          end
          if (q_r.wstb[1]) begin
            q_nxt.tos[15:8] = q_r.wdat[15:8];
          end
        end
        ADDR_CMD: begin
          // limits live in the shadow; the commit is done outside
          q_nxt.copy = q_r.wstb[0] && q_r.wdat[CMD_COPY_BIT];
        end
        default: q_nxt.bresp = RESP_SLVERR;
      endcase
    end
    // read path; a result read never touches the converter
    if (q_r.rvalid && rready) begin
      q_nxt.rvalid = 1'b0;
    end
    if (rd_go) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp  = RESP_OKAY;
      q_nxt.rdata  = 32'h0;
      case (8'(araddr))
        ADDR_TEMP: q_nxt.rdata[15:0] = q_r.temp;
        ADDR_CFG: begin
          q_nxt.rdata[6:0]         = q_r.cfg;
          q_nxt.rdata[CFG_NVB_BIT] = nv_busy;
        end
        ADDR_HYST: q_nxt.rdata[15:0] = q_r.hyst;
        ADDR_TOS:  q_nxt.rdata[15:0] = q_r.tos;
        ADDR_CMD:  ;
        default:   q_nxt.rresp = RESP_SLVERR;
      endcase
      if (q_r.cfg.mode) begin
        q_nxt.alarm = 1'b0;
      end
    end
    // conversion sequencing
    case (q_r.st)
      ST_START: begin
        q_nxt.start = 1'b1;
        q_nxt.st    = ST_CONV;
      end
      ST_CONV: begin
        if (tmr_done) begin
          q_nxt.temp = fmt;
          // a new event beats a same-cycle read clear
          if (q_r.cfg.mode || !q_r.alarm) begin
            if (hit && !q_r.alarm) begin
              if (3'(q_r.fcnt + 3'h1) >= tts_need(q_r.cfg.ft)) begin
                q_nxt.alarm     = 1'b1;
                q_nxt.fcnt      = 3'h0;
                q_nxt.low_phase = q_r.cfg.mode && !q_r.low_phase;
              end else begin
                q_nxt.fcnt = 3'(q_r.fcnt + 3'h1);
              end
            end else begin
              q_nxt.fcnt = 3'h0;
            end
          end else if (below) begin
            q_nxt.alarm = 1'b0;
            q_nxt.fcnt  = 3'h0;
          end
          if (q_r.cfg.sd) begin
            q_nxt.st = ST_SHUT;
            if (q_r.cfg.mode) begin
              // entering shutdown clears, even over a fresh event
              q_nxt.alarm = 1'b0;
              q_nxt.fcnt  = 3'h0;
            end
          end else begin
            q_nxt.st = ST_START;
          end
        end
      end
      ST_SHUT: begin
        if (!q_r.cfg.sd) begin
          q_nxt.st = ST_START;
        end
      end
      default: q_nxt.st = ST_START;
    endcase
    q_nxt.awready = !q_nxt.aw_got && !q_nxt.bvalid;
    q_nxt.wready  = !q_nxt.w_got && !q_nxt.bvalid;
    q_nxt.arready = !q_nxt.rvalid;
    // open drain: pull the pin low while its level must be low
    q_nxt.os_oe = q_nxt.alarm ^ q_nxt.cfg.alarm_active_level;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q_r           <= '0;
      q_r.st        <= ST_START;
      q_r.cfg       <= PWRUP_CFG;
      q_r.tos       <= TOS_RST;
      q_r.hyst      <= HYST_RST;
      q_r.os_oe     <= PWRUP_CFG.alarm_active_level;
      q_r.awready   <= 1'b1;
      q_r.wready    <= 1'b1;
      q_r.arready   <= 1'b1;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  assign awready    = q_r.awready;
  assign wready     = q_r.wready;
  assign bvalid     = q_r.bvalid;
  assign bresp      = q_r.bresp;
  assign arready    = q_r.arready;
  assign rvalid     = q_r.rvalid;
  assign rdata      = q_r.rdata;
  assign rresp      = q_r.rresp;
  assign conv_start = q_r.start;
  assign nv_copy    = q_r.copy;
  assign standby    = q_r.st[2];
  assign alarm_o    = 1'b0;
  assign alarm_oe   = q_r.os_oe;

  a_reset_dflt: assert property (@(posedge clk) disable iff (!rstn)
    !$past(rstn) |-> q_r.tos == TOS_RST && q_r.hyst == HYST_RST && q_r.st == ST_START)
    else $error("power-up values wrong");

  a_temp_format: assert property (@(posedge clk) disable iff (!rstn)
    ce && conv_end |=> q_r.temp == $past(fmt) && q_r.temp[3:0] == 4'h0
      && (q_r.temp & ~tts_res_mask($past(q_r.cfg.res))) == 16'h0)
    else $error("result not stored left-justified");

  a_pin_level: assert property (@(posedge clk) disable iff (!rstn)
    alarm_oe == (q_r.alarm ^ q_r.cfg.alarm_active_level) && alarm_o == 1'b0)
    else $error("alarm pin level does not follow polarity");

  a_shut_intclr: assert property (@(posedge clk) disable iff (!rstn)
    ce && conv_end && q_r.cfg.sd && q_r.cfg.mode |=> !q_r.alarm && q_r.st == ST_SHUT)
    else $error("interrupt alarm not cleared on shutdown");

  a_shut_cmphold: assert property (@(posedge clk) disable iff (!rstn)
    ce && conv_end && q_r.cfg.sd && !q_r.cfg.mode && !below |=> $stable(q_r.alarm))
    else $error("comparator alarm disturbed by shutdown");

  a_rd_clear: assert property (@(posedge clk) disable iff (!rstn)
    ce && rd_go && q_r.cfg.mode && !conv_end |=> !q_r.alarm)
    else $error("register read did not clear interrupt alarm");

  a_hyst_release: assert property (@(posedge clk) disable iff (!rstn)
    ce && conv_end && !q_r.cfg.mode && q_r.alarm && below |=> !q_r.alarm)
    else $error("comparator alarm not released below hysteresis");

  a_fault_one: assert property (@(posedge clk) disable iff (!rstn)
    ce && conv_end && !q_r.cfg.mode && !q_r.alarm && above && q_r.cfg.ft == 2'h0
      |=> q_r.alarm)
    else $error("single fault did not trigger alarm");

  a_sd_resume: assert property (@(posedge clk) disable iff (!rstn)
    ce && q_r.st == ST_SHUT && !q_r.cfg.sd |=> q_r.st == ST_START)
    else $error("clearing shutdown did not resume");

  a_bus_order: assert property (@(posedge clk) disable iff (!rstn)
    ce && rd_go && q_r.st == ST_CONV && !tmr_done |=> rvalid && q_r.st == ST_CONV)
    else $error("read answer missing");
endmodule

// ---- sim/tts_sensor_model.sv ----
`timescale 1ns/10ps
module tts_sensor_model #(
  parameter int NV_CYC = 20
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        conv_start,
  input  wire logic        nv_copy,
  input  wire logic [11:0] sample_in,
  output logic      [11:0] conv_data,
  output logic             nv_busy
);
  int left = 0;
  // sample frozen at start, so a late change cannot leak into a result
  always @(posedge clk) begin
    if (conv_start) conv_data <= sample_in;
    if (!rstn) left <= 0;
    else if (nv_copy) left <= NV_CYC;
    else if (left > 0) left <= left - 1;
  end
  assign nv_busy = left > 0;
endmodule

// ---- sim/tts_testbench.sv ----
`timescale 1ns/10ps
module testbench import tts_pkg::*;;
  localparam int B = 16;
  logic clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awready, wready, bvalid, arready, rvalid, conv_start, nv_copy, standby;
  logic alarm_o, alarm_oe, nv_busy;
  logic [1:0] bresp, rresp;
  logic [11:0] conv_data, temp_in = 0, cur = 0;
  logic [15:0] last_t;
  int fails = 0, checks = 0, seed = 95835, cyc = 0, live = 0, sb_q = 0;
  int alarm = 0, cnt = 0, under = 0, res = 0, ft = 0, alarm_active_level = 0, mode = 0;
  int tos = 'h5000, hyst = 'h4B00;
  int need[4] = '{1, 2, 4, 6};
  logic [11:0] tbl[9] = '{12'h7D0, 12'h191, 12'h0A2, 12'h008, 12'h000, 12'hFF8,
                          12'hF5E, 12'hE6F, 12'hC90};
  // open-drain pin with pull-up
  wire alarm_pin = alarm_oe ? alarm_o : 1'b1;

  tts_top #(.BASE_CYC(B)) dut (.clk(clk), .rstn(rstn), .ce(1'b1), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .conv_data(conv_data), .conv_start(conv_start), .nv_busy(nv_busy),
    .nv_copy(nv_copy), .standby(standby), .alarm_o(alarm_o), .alarm_oe(alarm_oe));
  tts_sensor_model model (.clk(clk), .rstn(rstn), .conv_start(conv_start),
    .nv_copy(nv_copy), .sample_in(temp_in), .conv_data(conv_data), .nv_busy(nv_busy));

  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  function automatic void ref_conv(input logic [11:0] x);
    int q, t, hit;
    q = 128 >> res;
    t = int'($signed({x, 4'h0})) & -q;
    last_t = t[15:0];
    if (!alarm) begin
      hit = (mode && under) ? t < (hyst & -q) : t > (tos & -q);
      cnt = hit ? cnt + 1 : 0;
      if (cnt == need[ft]) begin
        alarm = 1;
        cnt = 0;
        if (mode) under = !under;
      end
    end else if (!mode && t < (hyst & -q)) alarm = 0;
  endfunction

  // a conversion ends at each new start, or when standby rises
  always @(posedge clk) begin
    if (rstn && (conv_start || (standby && !sb_q))) begin
      if (live) ref_conv(cur);
      if (standby && mode) begin
        alarm = 0;
        cnt = 0;
      end
      live = conv_start;
      cur = temp_in;
    end
    sb_q = standby;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
    if (mode) alarm = 0;
  endtask

  task automatic sync;
    do @(posedge clk); while (!conv_start);
  endtask

  task automatic pin;
    chk("alarm_pin", 32'(alarm ? alarm_active_level : !alarm_active_level), 32'(alarm_pin));
  endtask

  task automatic setcfg(input int r, input int f, input int p, input int m, input int s);
    logic [1:0] b;
    res = r;
    ft = f;
    alarm_active_level = p;
    mode = m;
    wr(ADDR_CFG, 32'({r[1:0], f[1:0], p[0], m[0], s[0]}), b);
    chk("cfg_resp", 32'(RESP_OKAY), 32'(b));
  endtask

  task automatic lim(input logic [15:0] o, input logic [15:0] h);
    logic [1:0] b;
    tos = int'($signed(o));
    hyst = int'($signed(h));
    wr(ADDR_TOS, {16'h0, o}, b);
    wr(ADDR_HYST, {16'h0, h}, b);
  endtask

  task automatic step(input logic [11:0] x);
    logic [31:0] d;
    logic [1:0] r;
    temp_in <= x;
    sync;
    sync;
    repeat (2) @(posedge clk);
    pin;
    rd(ADDR_TEMP, d, r);
    chk("temp", {16'h0, last_t}, d);
  endtask

  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #300000;
    fails++;
    close_out;
  end

  initial begin
    logic [31:0] d;
    logic [1:0] b;
    int p[4];
    int n;
    repeat (6) @(posedge clk);
    rstn <= 1;
    rd(ADDR_CFG, d, b);
    chk("cfg_reset", 32'h0, d);
    rd(ADDR_TOS, d, b);
    chk("tos_reset", 32'h5000, d);
    rd(ADDR_HYST, d, b);
    chk("hyst_reset", 32'h4B00, d);
    wr(ADDR_TOS, 32'hFFFF_1234, b);
    rd(ADDR_TOS, d, b);
    chk("tos_rw", 32'h1230, d);
    wr(ADDR_HYST, 32'h0A20, b);
    rd(ADDR_HYST, d, b);
    chk("hyst_rw", 32'h0A20, d);
    wr(8'h14, 32'h1, b);
    chk("bad_wr", 32'(RESP_SLVERR), 32'(b));
    rd(8'h14, d, b);
    chk("bad_rd", 32'(RESP_SLVERR), 32'(b));
    chk("bad_data", 32'h0, d);
    wr(ADDR_CMD, 32'h1, b);
    rd(ADDR_CFG, d, b);
    chk("nv_busy", 32'h80, d);
    repeat (30) @(posedge clk);
    rd(ADDR_CFG, d, b);
    chk("nv_idle", 32'h0, d);
    $display("test registers done");
    sync;
    lim(16'h5000, 16'h4B00);
    for (int r = 0; r < 4; r++) begin
      sync;
      setcfg(r, 0, 0, 0, 0);
      foreach (tbl[i]) step(tbl[i]);
    end
    $display("test format done");
    sync;
    lim(16'h1900, 16'h1400);
    for (int i = 0; i < 16; i++) begin
      sync;
      setcfg(i % 4, i % 4, i / 4 % 2, i / 8, 0);
      for (int j = 0; j < 14; j++)
        step((j < 7 ? 12'h190 : 12'h132) + 12'($unsigned($random(seed)) % 16));
    end
    $display("test thermostat done");
    for (int r = 0; r < 4; r++) begin
      sync;
      setcfg(r, 0, 0, 0, 0);
      sync;
      n = cyc;
      rd(ADDR_TEMP, d, b);
      sync;
      p[r] = cyc - n;
      chk("period", 32'(p[0] + B * ((1 << r) - 1)), 32'(p[r]));
    end
    $display("test timing done");
    step(12'h1A0);
    sync;
    setcfg(0, 0, 0, 0, 1);
    do @(posedge clk); while (!standby);
    n = 0;
    repeat (200) begin
      @(posedge clk);
      n += conv_start;
    end
    pin;
    chk("idle_starts", 32'h0, 32'(n));
    rd(ADDR_TEMP, d, b);
    chk("sd_temp", 32'h1A00, d);
    setcfg(0, 0, 0, 0, 0);
    sync;
    step(12'h100);
    sync;
    setcfg(0, 0, 0, 1, 0);
    temp_in <= 12'h1A0;
    sync;
    sync;
    repeat (2) @(posedge clk);
    if (!alarm) begin
      temp_in <= 12'h100;
      sync;
      sync;
    end
    repeat (2) @(posedge clk);
    pin;
    setcfg(0, 0, 0, 1, 1);
    do @(posedge clk); while (!standby);
    repeat (2) @(posedge clk);
    pin;
    $display("test shutdown done");
    close_out;
  end
endmodule
